//--- common/periodic_timer_pkg.sv
/*
 Package for the periodic timer: register indices, field positions,
 mode and clock-source encodings, and the packed carriers.
 Assumes a classic Wishbone slave with 32-bit data, one register a word.
*/
package periodic_timer_pkg;
   localparam int CNT_W = 10;

   // Register byte addresses (one aligned word each)
   localparam logic [4:0] ADDR_CNT_LO  = 5'h00;
   localparam logic [4:0] ADDR_CNT_HI  = 5'h04;
   localparam logic [4:0] ADDR_CMPA_LO = 5'h08;
   localparam logic [4:0] ADDR_CMPA_HI = 5'h0c;
   localparam logic [4:0] ADDR_PER_LO  = 5'h10;
   localparam logic [4:0] ADDR_PER_HI  = 5'h14;
   localparam logic [4:0] ADDR_CTL0    = 5'h18;
   localparam logic [4:0] ADDR_CTL1    = 5'h1c;

   // Control register zero fields
   localparam int C0_HOLD_BIT = 7;
   localparam int C0_CLK_HI   = 6;
   localparam int C0_CLK_LO   = 4;
   localparam int C0_RUN_BIT  = 3;
   localparam logic [7:0] C0_WMASK = 8'hf8;

   // Control register one fields
   localparam int C1_MODE_HI = 7;
   localparam int C1_MODE_LO = 6;
   localparam int C1_PIN_HI  = 5;
   localparam int C1_PIN_LO  = 4;
   localparam int C1_INIT    = 3;
   localparam int C1_INV     = 2;
   localparam int C1_CAPSRC  = 1;
   localparam int C1_CLRSRC  = 0;

   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [CNT_W-1:0] CNT_MAX  = 10'h3ff;

   // Internal clock prescale division ratios
   localparam int DIV_SYS4  = 4;
   localparam int DIV_HI16  = 16;
   localparam int DIV_HI64  = 64;
   localparam int DIV_SUB   = 256;

   typedef enum logic [1:0] {
      MODE_CMP = 2'b00,
      MODE_CAP = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TMR = 2'b11
   } op_mode_t;

   typedef enum logic [2:0] {
      CK_SYS4  = 3'b000,
      CK_SYS   = 3'b001,
      CK_HI16  = 3'b010,
      CK_HI64  = 3'b011,
      CK_SUBA  = 3'b100,
      CK_SUBB  = 3'b101,
      CK_EXTR  = 3'b110,
      CK_EXTF  = 3'b111
   } clk_src_t;

   typedef struct packed {
      logic       hold;
      clk_src_t   clk_sel;
      logic       run;
   } ctl0_t;

   typedef struct packed {
      op_mode_t   mode;
      logic [1:0] pin_fn;
      logic       init_lvl;
      logic       invert;
      logic       cap_src;
      logic       clr_src;
   } ctl1_t;

   typedef struct packed {
      logic       out;
      logic       oe;
   } pin_drive_t;
endpackage

//--- design/periodic_timer.sv
/*
 Periodic timer: 10-bit up-counter, compare A and period comparators,
 compare output, PWM, single pulse, capture and timer modes.
 Assumes a classic Wishbone master on mclk; ext_clock_pin and
 capture_in_pin are asynchronous pins.
*/
`timescale 1ns/1ps
module periodic_timer
   import periodic_timer_pkg::*;
(
   input  wire logic        mclk,          // System clock, 100 MHz
   input  wire logic        resetn,        // Asynchronous reset, active low
   input  wire logic        clk_en,        // Freezes all state while low
   input  wire logic        hclk_tick,     // One-cycle tick of the high clock
   input  wire logic        subclk_tick,   // One-cycle tick of the subclock
   input  wire logic        wb_cyc_i,      // Wishbone cycle
   input  wire logic        wb_stb_i,      // Wishbone strobe
   input  wire logic        wb_we_i,       // Wishbone write enable
   input  wire logic [31:0] wb_adr_i,      // Wishbone byte address
   input  wire logic [31:0] wb_dat_i,      // Wishbone write data
   input  wire logic [3:0]  wb_sel_i,      // Wishbone byte selects
   output logic      [31:0] wb_dat_o,      // Wishbone read data
   output logic             wb_ack_o,      // Wishbone acknowledge
   output logic             wb_err_o,      // Wishbone error, unmapped address
   input  wire logic        ext_clock_pin, // External clock / trigger pin
   input  wire logic        capture_in_pin,// Capture input pin
   output logic             timer_out_pin, // Waveform output level
   output logic             timer_out_oe,  // High while the timer drives the pin
   output logic             match_a_flag,  // Pulse on compare A event
   output logic             match_p_flag,  // Pulse on period event
   output logic             capture_flag,  // Pulse on capture event
   output logic             timer_irq      // Pulse on any timer event
);
   ctl0_t            c0_r;
   ctl1_t            c1_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cmpa_r;
   logic [CNT_W-1:0] per_r;
   logic             run_d_r;
   logic             out_r;
   logic [7:0]       div_r;
   logic [2:0]       ext_s_r;
   logic [2:0]       cap_s_r;
   logic             ack_r;
   logic             err_r;
   logic [31:0]      rdat_r;
   logic             fa_r, fp_r, fc_r;

   // Pin synchronisers; stage 0 feeds stage 1 only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ext_s_r <= 3'h0;
         cap_s_r <= 3'h0;
      end else if (clk_en) begin
         ext_s_r <= {ext_s_r[1:0], ext_clock_pin};
         cap_s_r <= {cap_s_r[1:0], capture_in_pin};
      end
   end

   wire ext_rise = ext_s_r[1] & ~ext_s_r[2];
   wire ext_fall = ~ext_s_r[1] & ext_s_r[2];
   wire cap_rise = cap_s_r[1] & ~cap_s_r[2];
   wire cap_fall = ~cap_s_r[1] & cap_s_r[2];

   // Prescaler for the divided internal sources: system/4, high clock /16 and /64
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         div_r <= 8'h00;
      else if (clk_en)
         div_r <= div_r + 8'h01;
   end

   function automatic logic div_hit(input logic [7:0] d, input int n);
      div_hit = (d & 8'(n - 1)) == 8'h00;
   endfunction

   logic tick;
   always_comb begin
      case (c0_r.clk_sel)
         CK_SYS4: tick = div_hit(div_r, DIV_SYS4);
         CK_SYS:  tick = 1'b1;
         CK_HI16: tick = hclk_tick & div_hit(div_r, DIV_HI16);
         CK_HI64: tick = hclk_tick & div_hit(div_r, DIV_HI64);
         CK_SUBA: tick = subclk_tick;
         CK_SUBB: tick = subclk_tick;
         CK_EXTR: tick = ext_rise;
         CK_EXTF: tick = ext_fall;
         default: tick = 1'b0;
      endcase
   end

   wire mode_cmp = c1_r.mode == MODE_CMP;
   wire mode_cap = c1_r.mode == MODE_CAP;
   wire mode_pwm = c1_r.mode == MODE_PWM;
   wire mode_tmr = c1_r.mode == MODE_TMR;
   wire pulse_md = mode_pwm && (c1_r.pin_fn == 2'b11);

   wire run_rise = c0_r.run & ~run_d_r;
   wire advance  = c0_r.run & ~c0_r.hold & tick;
   wire hit_a    = cnt_r == cmpa_r;
   wire hit_p    = cnt_r == per_r;
   wire ev_a     = advance & hit_a;
   wire ev_p     = advance & hit_p;
   wire ovf      = advance & (cnt_r == CNT_MAX);

   // Clear source selection per mode
   logic clr_now;
   always_comb begin
      if (mode_cmp || mode_tmr) begin
         if (c1_r.clr_src)
            clr_now = ev_a;
         else
            clr_now = (per_r == CNT_ZERO) ? ovf : ev_p;
      end else if (pulse_md)
         clr_now = 1'b0;
      else
         clr_now = (per_r == CNT_ZERO) ? ovf : ev_p;
   end

   // Event flags; period flag is suppressed when compare A clears
   wire set_a = ev_a & ~mode_cap;
   wire set_p = ev_p & ~((mode_cmp | mode_tmr) & c1_r.clr_src);
   wire cap_edge_pin = c1_r.cap_src ? ext_s_r[1] : cap_s_r[1];
   wire cap_r_any = c1_r.cap_src ? ext_rise : cap_rise;
   wire cap_f_any = c1_r.cap_src ? ext_fall : cap_fall;
   logic cap_ev;
   always_comb begin
      case (c1_r.pin_fn)
         2'b00:   cap_ev = cap_r_any;
         2'b01:   cap_ev = cap_f_any;
         2'b10:   cap_ev = cap_r_any | cap_f_any;
         default: cap_ev = 1'b0;
      endcase
   end
   wire capture = mode_cap & c0_r.run & cap_ev;

   // Counter: software only clears it through the run rise
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_r   <= CNT_ZERO;
         run_d_r <= 1'b0;
      end else if (clk_en) begin
         run_d_r <= c0_r.run;
         if (run_rise)
            cnt_r <= CNT_ZERO;
         else if (clr_now)
            cnt_r <= CNT_ZERO;
         else if (advance)
            cnt_r <= cnt_r + 10'h001;
      end
   end

   // Compare output: level requested equal to current level leaves it alone
   logic out_nxt;
   always_comb begin
      out_nxt = out_r;
      if (run_rise && mode_cmp)
         out_nxt = c1_r.init_lvl;
      else if (ev_a && mode_cmp) begin
         case (c1_r.pin_fn)
            2'b01:   out_nxt = 1'b0;
            2'b10:   out_nxt = 1'b1;
            2'b11:   out_nxt = ~out_r;
            default: out_nxt = out_r;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         out_r <= 1'b0;
      else if (clk_en)
         out_r <= out_nxt;
   end

   // PWM duty: active while counter below compare A, full at or above period
   wire pwm_act = (cnt_r < cmpa_r) | ((per_r != CNT_ZERO) & (cmpa_r >= per_r));
   logic act;
   always_comb begin
      case (c1_r.pin_fn)
         2'b00:   act = 1'b0;
         2'b01:   act = 1'b1;
         2'b10:   act = pwm_act & c0_r.run;
         default: act = c0_r.run;
      endcase
   end
   wire pwm_lvl = c1_r.init_lvl ? act : ~act;
   wire base    = mode_pwm ? pwm_lvl : out_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         timer_out_pin <= 1'b0;
         timer_out_oe  <= 1'b0;
      end else if (clk_en) begin
         timer_out_pin <= base ^ c1_r.invert;
         timer_out_oe  <= ~mode_tmr & ~mode_cap;
      end
   end

   // Bus decode
   wire        req    = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
   wire [4:0]  adr    = wb_adr_i[4:0];
   wire        mapped = (wb_adr_i[31:5] == 27'h0) & (adr[1:0] == 2'b00);
   wire        wr     = req & mapped & wb_we_i & wb_sel_i[0];
   wire [7:0]  wd     = wb_dat_i[7:0];
   wire        wr_c0  = wr & (adr == ADDR_CTL0);
   wire        wr_c1  = wr & (adr == ADDR_CTL1);

   // Pulse mode: external active edge sets run, compare A clears it
   wire ext_trig = pulse_md & ~c0_r.run &
                   (c0_r.clk_sel == CK_EXTF ? ext_fall : ext_rise);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         c0_r   <= ctl0_t'(CTL_RESET[7:3]);
         c1_r   <= ctl1_t'(CTL_RESET);
         cmpa_r <= CNT_ZERO;
         per_r  <= CNT_ZERO;
      end else if (clk_en) begin
         if (wr_c0)
            c0_r <= ctl0_t'(wd[C0_HOLD_BIT:C0_RUN_BIT]);
         else if (pulse_md && ev_a)
            c0_r.run <= 1'b0;
         else if (ext_trig)
            c0_r.run <= 1'b1;
         if (wr_c1)
            c1_r <= ctl1_t'(wd);
         if (capture)
            cmpa_r <= cnt_r;
         else if (wr && adr == ADDR_CMPA_LO)
            cmpa_r[7:0] <= wd;
         else if (wr && adr == ADDR_CMPA_HI)
            cmpa_r[CNT_W-1:8] <= wd[1:0];
         if (wr && adr == ADDR_PER_LO)
            per_r[7:0] <= wd;
         else if (wr && adr == ADDR_PER_HI)
            per_r[CNT_W-1:8] <= wd[1:0];
      end
   end

   logic [7:0] rd;
   always_comb begin
      case (adr)
         ADDR_CNT_LO:  rd = cnt_r[7:0];
         ADDR_CNT_HI:  rd = {6'h00, cnt_r[CNT_W-1:8]};
         ADDR_CMPA_LO: rd = cmpa_r[7:0];
         ADDR_CMPA_HI: rd = {6'h00, cmpa_r[CNT_W-1:8]};
         ADDR_PER_LO:  rd = per_r[7:0];
         ADDR_PER_HI:  rd = {6'h00, per_r[CNT_W-1:8]};
         ADDR_CTL0:    rd = {c0_r, 3'h0};
         ADDR_CTL1:    rd = c1_r;
         default:      rd = 8'h00;
      endcase
   end

   // Events pulse for one cycle; the interrupt controller latches them
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_r  <= 1'b0;
         err_r  <= 1'b0;
         rdat_r <= 32'h0;
         fa_r   <= 1'b0;
         fp_r   <= 1'b0;
         fc_r   <= 1'b0;
      end else if (clk_en) begin
         ack_r  <= req & mapped;
         err_r  <= req & ~mapped;
         rdat_r <= (req & mapped & ~wb_we_i) ? {24'h0, rd} : 32'h0;
         fa_r   <= set_a;
         fp_r   <= set_p;
         fc_r   <= capture;
      end
   end

   assign wb_ack_o     = ack_r;
   assign wb_err_o     = err_r;
   assign wb_dat_o     = rdat_r;
   assign match_a_flag = fa_r;
   assign match_p_flag = fp_r;
   assign capture_flag = fc_r;
   assign timer_irq    = fa_r | fp_r | fc_r;

   wire unused_ok = cap_edge_pin;
endmodule

//--- bench/periodic_timer_asserts.sv
/*
 Checker for the periodic timer: bus answers and event outputs.
 Bound into the timer, sees only its ports; one clock domain.
*/
`timescale 1ns/1ps
module periodic_timer_asserts (
   input wire logic        mclk,         // Clock
   input wire logic        resetn,       // Reset, active low
   input wire logic        clk_en,       // Clock enable
   input wire logic        wb_cyc_i,     // Bus cycle
   input wire logic        wb_stb_i,     // Bus strobe
   input wire logic        wb_we_i,      // Bus write
   input wire logic [31:0] wb_adr_i,     // Bus address
   input wire logic [31:0] wb_dat_o,     // Read data
   input wire logic        wb_ack_o,     // Acknowledge
   input wire logic        wb_err_o,     // Error
   input wire logic        match_a_flag, // Compare A event
   input wire logic        match_p_flag, // Period event
   input wire logic        capture_flag, // Capture event
   input wire logic        timer_irq     // Event request
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   sequence s_req;
      wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_read;
      wb_ack_o && !wb_we_i;
   endsequence
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_req_answer: assert property (s_req |=> (wb_ack_o ^ wb_err_o))
      else $error("request not answered next cycle");
   a_err_unmapped: assert property (s_req ##0 (wb_adr_i > 32'h1c) |=> wb_err_o)
      else $error("unmapped address not refused");
   a_no_stray: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("answer without request");
   a_dat_upper: assert property (s_read |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_hi_byte: assert property (s_read ##0 (wb_adr_i[2] && wb_adr_i[4:3] != 2'b11)
      |-> wb_dat_o[7:2] == 6'h0)
      else $error("high byte unused bits set");
   a_ctl0_low: assert property (s_read ##0 (wb_adr_i[4:0] == 5'h18)
      |-> wb_dat_o[2:0] == 3'h0)
      else $error("control zero low bits set");
   a_irq_or: assert property (timer_irq == (match_a_flag || match_p_flag || capture_flag))
      else $error("request differs from events");
   a_cap_pulse: assert property (capture_flag |=> !capture_flag)
      else $error("capture event longer than a pulse");
endmodule
bind periodic_timer periodic_timer_asserts u_asserts (.mclk, .resetn, .clk_en, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .match_a_flag,
   .match_p_flag, .capture_flag, .timer_irq);

//--- bench/pin_partner.sv
/*
 Far-side pins of the timer: external clock and capture input.
 Assumes the caller runs tasks from the bench on mclk.
*/
`timescale 1ns/1ps
module pin_partner (
   input  wire logic mclk,           // System clock
   output logic      ext_clock_pin,  // External clock pin
   output logic      capture_in_pin  // Capture input pin
);
   initial begin
      ext_clock_pin = 1'b0;
      capture_in_pin = 1'b0;
   end
   // Levels held h+1 cycles: the synchroniser samples every mclk edge, so one cycle loses no edges
   task automatic flip(input bit ext, input int n, input int h);
      repeat (n) begin
         @(posedge mclk);
         if (ext) begin
            ext_clock_pin <= !ext_clock_pin;
         end else begin
            capture_in_pin <= !capture_in_pin;
         end
         repeat (h) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
   endtask
endmodule

//--- bench/periodic_timer_bench.sv
/*
 Random and directed bench for the periodic timer.
 Assumes pin_partner and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module periodic_timer_bench;
   import periodic_timer_pkg::*;
   logic        mclk, wb_ack_o, wb_err_o, re, ext_clock_pin, capture_in_pin;
   logic        timer_out_pin, timer_out_oe, match_a_flag, match_p_flag;
   logic        capture_flag, timer_irq, hclk_tick = 1'b0, subclk_tick = 1'b0;
   logic        resetn = 1'b0, clk_en = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_sel_i = 4'h1;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rnd, seed = 32'd99519;
   logic [7:0]  rq, a, d;
   logic [7:0]  ra [7] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
   int          miscompares, check_count, na, np, nc, t, g;

   periodic_timer dut (.mclk, .resetn, .clk_en, .hclk_tick, .subclk_tick, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
      .wb_err_o, .ext_clock_pin, .capture_in_pin, .timer_out_pin, .timer_out_oe,
      .match_a_flag, .match_p_flag, .capture_flag, .timer_irq);
   pin_partner pins (.mclk, .ext_clock_pin, .capture_in_pin);

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] msk(logic [7:0] ad, logic [7:0] dv);
      case (ad)
         8'h00: return 8'h00;
         8'h04, 8'h0c, 8'h14: return dv & 8'h03;
         8'h18: return dv & C0_WMASK;
         default: return dv;
      endcase
   endfunction
   function automatic logic lvl(logic [1:0] pf, logic init);
      return pf == 2'b00 ? init : pf == 2'b11 ? !init : pf[1];
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("mismatches %0d checks %0d", miscompares, check_count);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic bus(logic we, logic [7:0] ad, logic [7:0] dv);
      int n;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {24'h0, ad};
      wb_dat_i <= {24'h0, dv};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (!wb_ack_o && !wb_err_o && n < 50);
      chk(n < 50, 1);
      rq = wb_dat_o[7:0];
      re = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Counts cycles to the next compare A (p=0) or period (p=1) event
   task automatic wev(bit p, output int c);
      int s;
      s = p ? np : na;
      c = 0;
      while ((p ? np : na) == s && c < 3000) begin
         @(posedge mclk);
         c++;
      end
      chk(c < 3000, 1);
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = !mclk;
   end
   // Event tallies settle one edge late, so waits never race the flags
   always @(posedge mclk) begin
      rnd = xs();
      hclk_tick <= rnd[0];
      subclk_tick <= rnd[5];
      na <= na + match_a_flag;
      np <= np + match_p_flag;
      nc <= nc + capture_flag;
   end
   initial begin
      #500us;
      miscompares++;
      end_sim();
   end

   initial begin
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         bus(0, 8'(k * 4), 8'h00);
         chk(rq, 8'h00);
      end
      bus(0, 8'h20, 8'h00);
      chk({re, rq}, 9'h100);
      bus(1, 8'h02, 8'h5a);
      chk(re, 1'b1);
      // Run bit kept low so the counter must read zero
      for (int k = 0; k < 24; k++) begin
         a = ra[xs() % 7];
         d = 8'(xs()) & 8'hf7;
         bus(1, a, d);
         bus(0, a, 8'h00);
         chk(rq, msk(a, d));
      end
      bus(1, 8'h18, 8'h00);
      bus(1, 8'h08, 8'h05);
      bus(1, 8'h0c, 8'h00);
      bus(1, 8'h10, 8'h14);
      bus(1, 8'h14, 8'h00);
      for (int k = 0; k < 4; k++) begin
         bus(1, 8'h1c, 8'(k << 6));
         bus(1, 8'h18, 8'h18);
         repeat (3) @(posedge mclk);
         chk(timer_out_oe, k[0] == 1'b0);
         bus(1, 8'h18, 8'h00);
      end
      for (int k = 0; k < 16; k++) begin
         bus(1, 8'h18, 8'h00);
         bus(1, 8'h1c, 8'(k << 2));
         bus(1, 8'h18, 8'h18);
         repeat (3) @(posedge mclk);
         chk(timer_out_pin, k[1] ^ k[0]);
         wev(0, t);
         @(posedge mclk);
         chk(timer_out_pin, lvl(2'(k >> 2), k[1]) ^ k[0]);
      end
      wev(1, t);
      wev(1, t);
      chk(t == 20 || t == 21, 1);
      bus(1, 8'h1c, 8'h01);
      wev(0, t);
      wev(0, t);
      chk(t == 5 || t == 6, 1);
      t = np;
      repeat (60) @(posedge mclk);
      chk(np, t);
      bus(1, 8'h18, 8'h98);
      repeat (3) @(posedge mclk);
      t = na;
      bus(0, 8'h00, 8'h00);
      d = rq;
      repeat (20) @(posedge mclk);
      bus(0, 8'h00, 8'h00);
      chk(na, t);
      chk(rq, d);
      bus(1, 8'h18, 8'h18);
      wev(0, t);
      for (int k = 6; k < 8; k++) begin
         bus(1, 8'h18, 8'h00);
         bus(1, 8'h1c, 8'hc0);
         bus(1, 8'h18, 8'(k << 4 | 8));
         pins.flip(1'b1, 6, 4 + xs() % 3);
         bus(1, 8'h18, 8'h00);
         bus(0, 8'h00, 8'h00);
         chk(rq, 8'h03);
      end
      bus(1, 8'h18, 8'h68);
      bus(1, 8'h18, 8'h00);
      bus(0, 8'h00, 8'h00);
      chk(rq, 8'h00);
      for (int k = 0; k < 8; k++) begin
         bus(1, 8'h18, 8'h00);
         bus(1, 8'h1c, {2'b01, 2'(k), 2'b00, k[2], 1'b0});
         bus(1, 8'h18, 8'h18);
         t = nc;
         pins.flip(k[2], 2, 4 + xs() % 3);
         chk(nc - t, k[1:0] == 2 ? 2 : k[1:0] == 3 ? 0 : 1);
      end
      // Capture overwrote compare A, so restore it before the PWM run
      bus(1, 8'h18, 8'h00);
      bus(1, 8'h08, 8'h05);
      bus(1, 8'h0c, 8'h00);
      bus(1, 8'h1c, 8'ha8);
      bus(1, 8'h18, 8'h18);
      repeat (8) @(posedge mclk);
      g = 0;
      repeat (42) begin
         @(posedge mclk);
         g += timer_out_pin;
      end
      chk(g, 10);
      // Pulse mode: pin edge starts the run, compare A ends it
      bus(1, 8'h18, 8'h00);
      bus(1, 8'h1c, 8'hb8);
      bus(1, 8'h18, 8'h10);
      t = na;
      pins.flip(1'b1, 1, 12);
      bus(0, 8'h18, 8'h00);
      chk(rq, 8'h10);
      chk(na - t, 1);
      end_sim();
   end
endmodule
